// ---- bench/wake_irq_flags_tb_top.sv ----
/*
 * Self-checking bench for the wake and interrupt enable flags.
 * Assumes the partner model drives all design inputs except clock and reset.
 */
`timescale 1ns/100ps
module wake_irq_flags_tb_top;
	logic mclk;
	logic rst_n;
	logic instrValid;
	logic [15:0] instrWord;
	logic evtDivOvf, evtTmr0Unf, evtSerRx, evtSerTx, evtTmr1Unf;
	logic [3:0] wakePortPin;
	logic intPin;
	logic [7:0] holdEnable, irqEnable, wakeSource, irqAccept;
	logic holdRelease, irqAny;
	logic [7:0] hExp, iExp;
	int errorCnt = 0;
	int nChecks = 0;

	wif_partner wif_partner_i (.mclk(mclk), .instrValid(instrValid), .instrWord(instrWord),
		.evtDivOvf(evtDivOvf), .evtTmr0Unf(evtTmr0Unf), .evtSerRx(evtSerRx), .evtSerTx(evtSerTx),
		.evtTmr1Unf(evtTmr1Unf), .wakePortPin(wakePortPin), .intPin(intPin));

	wake_irq_flags wake_irq_flags_i (.mclk(mclk), .rst_n(rst_n), .instrValid(instrValid),
		.instrWord(instrWord), .evtDivOvf(evtDivOvf), .evtTmr0Unf(evtTmr0Unf), .evtSerRx(evtSerRx),
		.evtSerTx(evtSerTx), .evtTmr1Unf(evtTmr1Unf), .wakePortPin(wakePortPin), .intPin(intPin),
		.holdEnable(holdEnable), .irqEnable(irqEnable), .holdRelease(holdRelease),
		.wakeSource(wakeSource), .irqAccept(irqAccept), .irqAny(irqAny));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic endOfTest();
		if (errorCnt == 0 && nChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : endOfTest

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	task automatic regs();
		chk("holdEnable", holdEnable, hExp);
		chk("irqEnable", irqEnable, iExp);
	endtask : regs

	task automatic load(input logic [7:0] opc, input logic [7:0] imm);
		wif_partner_i.issue(opc, imm);
		wif_partner_i.idle();
		if (opc === wif_pkg::OPC_HOLD_EN) hExp = imm & wif_pkg::FLAG_WRITE_MASK;
		if (opc === wif_pkg::OPC_IRQ_EN) iExp = imm & wif_pkg::FLAG_WRITE_MASK;
		regs();
	endtask : load

	// Pin events arrive after the synchroniser, so the outputs are watched over a window.
	task automatic evt(input int b);
		logic [7:0] src, acc, bit1;
		int relCnt, anyCnt;
		src = 8'h00;
		acc = 8'h00;
		relCnt = 0;
		anyCnt = 0;
		bit1 = 8'h01 << b;
		wif_partner_i.fire(b);
		for (int k = 0; k < 6; k++) begin
			relCnt += int'(holdRelease !== 1'b0);
			anyCnt += int'(irqAny !== 1'b0);
			src |= wakeSource;
			acc |= irqAccept;
			@(negedge mclk);
		end
		chk("holdRelease", 8'(relCnt), {7'h00, hExp[b]});
		chk("wakeSource", src, hExp & bit1);
		chk("irqAccept", acc, iExp & bit1);
		chk("irqAny", 8'(anyCnt), {7'h00, iExp[b]});
		if (b == 4) begin
			wif_partner_i.restore();
			repeat (6) @(negedge mclk);
		end
	endtask : evt

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		hExp = wif_pkg::FLAG_RESET;
		iExp = wif_pkg::FLAG_RESET;
		repeat (4) @(negedge mclk);
		regs();
		rst_n = 1'b1;
		@(negedge mclk);
		regs();
		load(wif_pkg::OPC_HOLD_EN, 8'hff);
		load(wif_pkg::OPC_IRQ_EN, 8'hff);
		wif_partner_i.issue(wif_pkg::OPC_HOLD_EN, 8'ha5);
		wif_partner_i.issue(wif_pkg::OPC_IRQ_EN, 8'h5a);
		wif_partner_i.issue(8'h42, 8'h00);
		wif_partner_i.idle();
		hExp = 8'ha5;
		iExp = 8'h52;
		regs();
		for (int b = 0; b < 8; b++) begin
			if (b != 3) begin
				load(wif_pkg::OPC_HOLD_EN, 8'h01 << b);
				load(wif_pkg::OPC_IRQ_EN, ~(8'h01 << b));
				evt(b);
				load(wif_pkg::OPC_HOLD_EN, ~(8'h01 << b));
				load(wif_pkg::OPC_IRQ_EN, 8'h01 << b);
				evt(b);
			end
		end
		@(negedge mclk);
		rst_n = 1'b0;
		hExp = wif_pkg::FLAG_RESET;
		iExp = wif_pkg::FLAG_RESET;
		@(negedge mclk);
		regs();
		rst_n = 1'b1;
		evt(0);
		// A load and an event in one cycle: the event still sees the flags held before the load.
		fork
			wif_partner_i.issue(wif_pkg::OPC_HOLD_EN, 8'hff);
			wif_partner_i.fire(0);
		join
		chk("holdRelease", {7'h00, holdRelease}, 8'h00);
		wif_partner_i.idle();
		hExp = wif_pkg::FLAG_WRITE_MASK;
		regs();
		evt(0);
		endOfTest();
	end

	// The tests take well under 2000 cycles; this margin only catches a hang.
	initial begin
		#200000;
		errorCnt++;
		endOfTest();
	end
endmodule : wake_irq_flags_tb_top

// ---- bench/wif_partner.sv ----
/*
 * Model of the instruction decoder and event sources that feed the enable flags.
 * Assumes its tasks are called from the bench and that inputs move at falling mclk.
 */
`timescale 1ns/100ps
module wif_partner (
	input wire logic mclk,
	output logic instrValid,
	output logic [15:0] instrWord,
	output logic evtDivOvf,
	output logic evtTmr0Unf,
	output logic evtSerRx,
	output logic evtSerTx,
	output logic evtTmr1Unf,
	output logic [3:0] wakePortPin,
	output logic intPin
);
	initial begin
		instrValid = 1'b0;
		instrWord = 16'h0000;
		{evtDivOvf, evtTmr0Unf, evtSerRx, evtSerTx, evtTmr1Unf} = 5'h00;
		wakePortPin = 4'h0;
		intPin = 1'b1;
	end

	// ****************************************************************
	// Instruction strobe
	// ****************************************************************
	// The strobe stays up so that loads can follow back to back.
	task automatic issue(input logic [7:0] opc, input logic [7:0] imm);
		@(negedge mclk);
		instrValid = 1'b1;
		instrWord = {opc, imm};
	endtask : issue

	// A released word is inverted so a stale value is never mistaken for a fresh one.
	task automatic idle();
		@(negedge mclk);
		instrValid = 1'b0;
		instrWord = ~instrWord;
	endtask : idle

	// ****************************************************************
	// Event sources
	// ****************************************************************
	task automatic fire(input int b);
		@(negedge mclk);
		case (b)
			0: evtDivOvf = 1'b1;
			1: evtTmr0Unf = 1'b1;
			2: wakePortPin[0] = ~wakePortPin[0];
			4: intPin = 1'b0;
			5: evtSerRx = 1'b1;
			6: evtSerTx = 1'b1;
			default: evtTmr1Unf = 1'b1;
		endcase
		@(negedge mclk);
		{evtDivOvf, evtTmr0Unf, evtSerRx, evtSerTx, evtTmr1Unf} = 5'h00;
	endtask : fire

	// A rising edge on the interrupt pin is not an event, so restoring it is silent.
	task automatic restore();
		@(negedge mclk);
		intPin = 1'b1;
	endtask : restore
endmodule : wif_partner

// ---- common/wif_load_if.sv ----
/*
 * Load channel between the top module and one enable register.
 * Assumes the writer drives load and data on the same clock as the holder.
 */
`timescale 1ns/100ps
interface wif_load_if;
	logic load;
	logic [7:0] data;
	logic [7:0] flags;

	modport writer (output load, output data, input flags);
	modport holder (input load, input data, output flags);
endinterface : wif_load_if

// ---- common/wif_pkg.sv ----
/*
 * Constants shared by the wake and interrupt enable flag block: instruction
 * opcodes, event bit positions, reset values and widths.
 * Assumes a 16-bit instruction word whose upper byte is the opcode and whose
 * lower byte is the immediate operand.
 */
package wif_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int FLAG_W = 8;
	localparam int INSTR_W = 16;
	localparam int PORT_W = 4;
	localparam int OPC_MSB = 15;
	localparam int OPC_LSB = 8;
	localparam int IMM_MSB = 7;
	localparam int IMM_LSB = 0;

	// ****************************************************************
	// Opcodes of the two loading instructions
	// ****************************************************************
	localparam logic [7:0] OPC_HOLD_EN = 8'h43;
	localparam logic [7:0] OPC_IRQ_EN = 8'h51;

	// ****************************************************************
	// Event bit positions, shared by both enable registers
	// ****************************************************************
	localparam int EVT_DIV_OVF = 0;
	localparam int EVT_TMR0_UNF = 1;
	localparam int EVT_PORT_CHG = 2;
	localparam int EVT_RESERVED = 3;
	localparam int EVT_INT_FALL = 4;
	localparam int EVT_SER_RX = 5;
	localparam int EVT_SER_TX = 6;
	localparam int EVT_TMR1_UNF = 7;

	// ****************************************************************
	// Reset values and masks
	// ****************************************************************
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] FLAG_WRITE_MASK = 8'hf7;
	localparam logic [3:0] PORT_RESET = 4'h0;
	localparam logic INT_PIN_RESET = 1'b1;

endpackage : wif_pkg

// ---- src/wake_irq_flags.sv ----
/*
 * Hold-release and interrupt enable flags with event gating.
 * Assumes the instruction decoder presents one instruction per strobe on mclk,
 * internal event pulses are one mclk cycle wide on the same clock, and the
 * wake input port and external interrupt pin are asynchronous pins.
 */
// Functional notes
// - Opcode byte 0x43 loads the immediate into the hold-release enable register in one cycle.
// - Hold-release bit 0 lets a divider overflow release hold.
// - Hold-release bit 1 lets a timer 0 underflow release hold.
// - Hold-release bit 2 lets a change on the wake input port release hold.
// - Hold-release bit 4 lets a falling edge on the interrupt pin release hold.
// - Hold-release bit 5 lets serial receive completion release hold.
// - Hold-release bit 6 lets serial transmit completion release hold.
// - Hold-release bit 7 lets a timer 1 underflow release hold.
// - Opcode byte 0x51 loads the immediate into the interrupt enable register in one cycle.
// - Interrupt enable bit n lets event n be accepted, same sources and order as hold release.
`timescale 1ns/100ps
module wake_irq_flags (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic instrValid,
	input wire logic [15:0] instrWord,
	input wire logic evtDivOvf,
	input wire logic evtTmr0Unf,
	input wire logic evtSerRx,
	input wire logic evtSerTx,
	input wire logic evtTmr1Unf,
	input wire logic [3:0] wakePortPin,
	input wire logic intPin,
	output logic [7:0] holdEnable,
	output logic [7:0] irqEnable,
	output logic holdRelease,
	output logic [7:0] wakeSource,
	output logic [7:0] irqAccept,
	output logic irqAny
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic isOpcode(input logic [15:0] word, input logic [7:0] opc);
		isOpcode = (word[wif_pkg::OPC_MSB:wif_pkg::OPC_LSB] == opc);
	endfunction : isOpcode

	function automatic logic [7:0] gateEvents(input logic [7:0] evt, input logic [7:0] enable);
		gateEvents = evt & enable & wif_pkg::FLAG_WRITE_MASK;
	endfunction : gateEvents

	// ****************************************************************
	// Instruction decode and enable registers
	// ****************************************************************
	wif_load_if holdLoad ();
	wif_load_if irqLoad ();

	logic loadHold;
	logic loadIrq;
	logic [7:0] immediate;

	assign immediate = instrWord[wif_pkg::IMM_MSB:wif_pkg::IMM_LSB];
	assign loadHold = instrValid && isOpcode(instrWord, wif_pkg::OPC_HOLD_EN);
	assign loadIrq = instrValid && isOpcode(instrWord, wif_pkg::OPC_IRQ_EN);

	assign holdLoad.load = loadHold;
	assign holdLoad.data = immediate;
	assign irqLoad.load = loadIrq;
	assign irqLoad.data = immediate;

	wif_enable_reg u_holdReg (
		.mclk(mclk),
		.rst_n(rst_n),
		.loadPort(holdLoad.holder)
	);

	wif_enable_reg u_irqReg (
		.mclk(mclk),
		.rst_n(rst_n),
		.loadPort(irqLoad.holder)
	);

	assign holdEnable = holdLoad.flags;
	assign irqEnable = irqLoad.flags;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [3:0] portSync;
	logic [3:0] portChange;
	logic intSync;
	logic intFall;

	// The port is idle low and the interrupt pin idle high, so reset does not fake an edge.
	wif_pin_sync #(
		.WIDTH(wif_pkg::PORT_W),
		.INIT(wif_pkg::PORT_RESET)
	) u_portSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pinIn(wakePortPin),
		.pinSync(portSync),
		.pinChange(portChange),
		.pinFall()
	);

	wif_pin_sync #(
		.WIDTH(1),
		.INIT(wif_pkg::INT_PIN_RESET)
	) u_intSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pinIn(intPin),
		.pinSync(intSync),
		.pinChange(),
		.pinFall(intFall)
	);

	// ****************************************************************
	// Event vector
	// ****************************************************************
	logic [7:0] evtVec;

	always_comb begin
		evtVec = 8'h00;
		evtVec[wif_pkg::EVT_DIV_OVF] = evtDivOvf;
		evtVec[wif_pkg::EVT_TMR0_UNF] = evtTmr0Unf;
		evtVec[wif_pkg::EVT_PORT_CHG] = |portChange;
		evtVec[wif_pkg::EVT_RESERVED] = 1'b0;
		evtVec[wif_pkg::EVT_INT_FALL] = intFall;
		evtVec[wif_pkg::EVT_SER_RX] = evtSerRx;
		evtVec[wif_pkg::EVT_SER_TX] = evtSerTx;
		evtVec[wif_pkg::EVT_TMR1_UNF] = evtTmr1Unf;
	end

	// ****************************************************************
	// Hold release
	// ****************************************************************
	// An event in the cycle of a load is gated by the flags held before the load.
	logic [7:0] nxt_wakeSource;
	logic [7:0] wakeSource_ff;
	logic holdRelease_ff;
	logic holdHit;

	assign nxt_wakeSource = gateEvents(evtVec, holdEnable);
	assign holdHit = |(evtVec & holdEnable);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wakeSource_ff <= wif_pkg::FLAG_RESET;
			holdRelease_ff <= 1'b0;
		end else begin
			wakeSource_ff <= nxt_wakeSource;
			holdRelease_ff <= |nxt_wakeSource;
		end
	end

	assign wakeSource = wakeSource_ff;
	assign holdRelease = holdRelease_ff;

	// ****************************************************************
	// Interrupt acceptance
	// ****************************************************************
	logic [7:0] nxt_irqAccept;
	logic [7:0] irqAccept_ff;
	logic irqAny_ff;
	logic irqHit;

	assign nxt_irqAccept = gateEvents(evtVec, irqEnable);
	assign irqHit = |(evtVec & irqEnable);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqAccept_ff <= wif_pkg::FLAG_RESET;
			irqAny_ff <= 1'b0;
		end else begin
			irqAccept_ff <= nxt_irqAccept;
			irqAny_ff <= |nxt_irqAccept;
		end
	end

	assign irqAccept = irqAccept_ff;
	assign irqAny = irqAny_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_holdLoad;
		@(posedge mclk) disable iff (!rst_n)
		loadHold |=> (holdEnable == ($past(immediate) & wif_pkg::FLAG_WRITE_MASK));
	endproperty
	a_holdLoad: assert property (p_holdLoad) else $error("hold enable not loaded from immediate");

	property p_holdKeep;
		@(posedge mclk) disable iff (!rst_n)
		!loadHold |=> $stable(holdEnable);
	endproperty
	a_holdKeep: assert property (p_holdKeep) else $error("hold enable changed without its opcode");

	property p_irqLoad;
		@(posedge mclk) disable iff (!rst_n)
		loadIrq |=> (irqEnable == ($past(immediate) & wif_pkg::FLAG_WRITE_MASK));
	endproperty
	a_irqLoad: assert property (p_irqLoad) else $error("irq enable not loaded from immediate");

	property p_irqKeep;
		@(posedge mclk) disable iff (!rst_n)
		!loadIrq |=> $stable(irqEnable);
	endproperty
	a_irqKeep: assert property (p_irqKeep) else $error("irq enable changed without its opcode");

	property p_divWake;
		@(posedge mclk) disable iff (!rst_n)
		(evtDivOvf && holdEnable[wif_pkg::EVT_DIV_OVF]) |=> (holdRelease && wakeSource[wif_pkg::EVT_DIV_OVF]);
	endproperty
	a_divWake: assert property (p_divWake) else $error("divider overflow did not release hold");

	property p_tmr0Wake;
		@(posedge mclk) disable iff (!rst_n)
		(evtTmr0Unf && holdEnable[wif_pkg::EVT_TMR0_UNF]) |=> (holdRelease && wakeSource[wif_pkg::EVT_TMR0_UNF]);
	endproperty
	a_tmr0Wake: assert property (p_tmr0Wake) else $error("timer 0 underflow did not release hold");

	property p_portWake;
		@(posedge mclk) disable iff (!rst_n)
		($changed(portSync) && holdEnable[wif_pkg::EVT_PORT_CHG]) |-> ##1 holdRelease;
	endproperty
	a_portWake: assert property (p_portWake) else $error("port change did not release hold");

	property p_intWake;
		@(posedge mclk) disable iff (!rst_n)
		($fell(intSync) && holdEnable[wif_pkg::EVT_INT_FALL]) |-> ##1 (holdRelease && wakeSource[wif_pkg::EVT_INT_FALL]);
	endproperty
	a_intWake: assert property (p_intWake) else $error("interrupt pin fall did not release hold");

	property p_rxWake;
		@(posedge mclk) disable iff (!rst_n)
		(evtSerRx && holdEnable[wif_pkg::EVT_SER_RX]) |=> wakeSource[wif_pkg::EVT_SER_RX];
	endproperty
	a_rxWake: assert property (p_rxWake) else $error("receive completion did not release hold");

	property p_txWake;
		@(posedge mclk) disable iff (!rst_n)
		(evtSerTx && holdEnable[wif_pkg::EVT_SER_TX]) |=> wakeSource[wif_pkg::EVT_SER_TX];
	endproperty
	a_txWake: assert property (p_txWake) else $error("transmit completion did not release hold");

	property p_tmr1Wake;
		@(posedge mclk) disable iff (!rst_n)
		(evtTmr1Unf && holdEnable[wif_pkg::EVT_TMR1_UNF]) |=> wakeSource[wif_pkg::EVT_TMR1_UNF];
	endproperty
	a_tmr1Wake: assert property (p_tmr1Wake) else $error("timer 1 underflow did not release hold");

	property p_irqGate;
		@(posedge mclk) disable iff (!rst_n)
		##1 (irqAccept == ($past(evtVec) & $past(irqEnable)));
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("accepted interrupts do not match enabled events");

	property p_irqSameOrder;
		@(posedge mclk) disable iff (!rst_n)
		(holdEnable == irqEnable) |=> (wakeSource == irqAccept);
	endproperty
	a_irqSameOrder: assert property (p_irqSameOrder) else $error("interrupt and wake bit order differ");

	property p_blocked;
		@(posedge mclk) disable iff (!rst_n)
		holdRelease |-> $past(holdHit);
	endproperty
	a_blocked: assert property (p_blocked) else $error("hold released by a disabled event");

	property p_holdAny;
		@(posedge mclk) disable iff (!rst_n)
		holdRelease == (|wakeSource);
	endproperty
	a_holdAny: assert property (p_holdAny) else $error("hold release does not match its sources");

	property p_irqAny;
		@(posedge mclk) disable iff (!rst_n)
		irqAny == (|irqAccept);
	endproperty
	a_irqAny: assert property (p_irqAny) else $error("interrupt summary does not match accepted bits");

	property p_irqBlocked;
		@(posedge mclk) disable iff (!rst_n)
		irqAny |-> $past(irqHit);
	endproperty
	a_irqBlocked: assert property (p_irqBlocked) else $error("interrupt accepted from a disabled event");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_n)
		!holdEnable[wif_pkg::EVT_RESERVED] && !irqEnable[wif_pkg::EVT_RESERVED]
			&& !wakeSource[wif_pkg::EVT_RESERVED] && !irqAccept[wif_pkg::EVT_RESERVED];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit took effect");

	property p_resetClear;
		@(posedge mclk)
		!rst_n |-> (holdEnable == wif_pkg::FLAG_RESET && irqEnable == wif_pkg::FLAG_RESET && !holdRelease);
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("enable flags not clear in reset");

endmodule : wake_irq_flags

// ---- src/wif_enable_reg.sv ----
/*
 * One 8-bit enable flag register, loaded whole from the load channel.
 * Assumes the writer has already decoded the instruction; the reserved bit
 * is forced to zero here so no caller can set it.
 */
`timescale 1ns/100ps
module wif_enable_reg (
	input wire logic mclk,
	input wire logic rst_n,
	wif_load_if.holder loadPort
);
	logic [7:0] flags_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= wif_pkg::FLAG_RESET;
		end else if (loadPort.load) begin
			flags_ff <= loadPort.data & wif_pkg::FLAG_WRITE_MASK;
		end
	end

	assign loadPort.flags = flags_ff;
endmodule : wif_enable_reg

// ---- src/wif_pin_sync.sv ----
/*
 * Two-stage synchroniser for pin inputs with a third stage for edge detection.
 * Assumes the pins are asynchronous to mclk; edges are reported one to two
 * clocks after the pin moves.
 */
`timescale 1ns/100ps
module wif_pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync,
	output logic [WIDTH-1:0] pinChange,
	output logic [WIDTH-1:0] pinFall
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;

	// The first stage is read only by the second stage.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= INIT;
			sync_ff <= INIT;
			prev_ff <= INIT;
		end else begin
			meta_ff <= pinIn;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign pinSync = sync_ff;
	assign pinChange = sync_ff ^ prev_ff;
	assign pinFall = prev_ff & ~sync_ff;
endmodule : wif_pin_sync
